// file: shared/scs_defines.svh
// Offsets, field positions, encodings and widths for the context select block
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_ADDR_W 52
`define SCS_SSID_W 20
`define SCS_PTR_HI 51
`define SCS_PTR_LO 6
`define SCS_CD_SHIFT 6
`define SCS_FMT_LINEAR 2'h0
`define SCS_FMT_L2_4K 2'h1
`define SCS_FMT_L2_64K 2'h2
`define SCS_DSS_TERM 2'h0
`define SCS_DSS_BYPASS 2'h1
`define SCS_DSS_SUB0 2'h2
`define SCS_L2_4K_BITS 6
`define SCS_L2_64K_BITS 10
`define SCS_L1_ENTRY_SHIFT 3
`define SCS_L2_4K_ALIGN 12
`define SCS_L2_64K_ALIGN 16
`define SCS_REG_CTRL 4'h0
`define SCS_REG_PTR_LO 4'h1
`define SCS_REG_PTR_HI 4'h2
`define SCS_REG_FIELDS 4'h3
`define SCS_REG_CAPS 4'h4
`define SCS_REG_EVENTS 4'h5
`define SCS_REG_COUNT 4'h6
`define SCS_CTRL_RST 3'h0
`define SCS_IAS_RST 6'h30
`endif

// file: shared/scs_pkg.sv
// Types shared by the context select block
package scs_pkg;
	typedef enum logic [2:0] {
		SCS_RES_NONE,
		SCS_RES_BAD_SUBSTREAM,
		SCS_RES_STREAM_DISABLED,
		SCS_RES_S1_BYPASS,
		SCS_RES_S1_ADDR_SIZE,
		SCS_RES_FETCH_CD,
		SCS_RES_FETCH_L1
	} scs_result_t;

	typedef struct packed {
		logic [19:0] sub_flow_index;
		logic has_index;
		logic [51:0] input_addr;
	} scs_txn_t;

	typedef struct packed {
		scs_result_t result;
		logic [51:0] fetch_addr;
		logic addr_is_ipa;
		logic s2_after;
		logic [9:0] l2_index;
	} scs_ans_t;
endpackage : scs_pkg

// file: rtl/scs_index_calc.sv
// Combinational index and address former for descriptor fetches
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_index_calc (
	input wire logic [45:0] ctx_ptr_i,
	input wire logic [1:0] fmt_i,
	input wire logic [4:0] count_log2_i,
	input wire logic [19:0] index_i,
	output logic [51:0] addr_o,
	output logic two_level_o,
	output logic [9:0] l2_index_o
);
	import scs_pkg::*;

	// Keep only the low n bits of an index
	function automatic logic [19:0] scs_low_bits(input logic [19:0] v, input logic [4:0] n);
		logic [20:0] m;
		m = (21'h1 << n) - 21'h1;
		scs_low_bits = v & m[19:0];
	endfunction : scs_low_bits

	logic [51:0] base;
	logic [19:0] lin_idx;
	logic [19:0] l1_idx;
	logic [19:0] masked;
	logic [51:0] align_mask;

	assign base = {ctx_ptr_i, 6'h00}; // [R05]
	assign masked = scs_low_bits(index_i, count_log2_i);

	// A linear table base is size aligned, so pointer bits inside the span read as zero
	always_comb begin
		lin_idx = masked;
		l1_idx = 20'h0_0000;
		align_mask = {52{1'b1}};
		two_level_o = 1'b0;
		l2_index_o = 10'h000;
		addr_o = base;
		if (fmt_i == `SCS_FMT_L2_4K) begin
			two_level_o = 1'b1;
			l1_idx = masked >> `SCS_L2_4K_BITS; // [R21]
			l2_index_o = {4'h0, index_i[5:0]}; // [R21]
			addr_o = base + {29'h0, l1_idx, 3'h0};
		end else if (fmt_i == `SCS_FMT_L2_64K) begin
			two_level_o = 1'b1;
			l1_idx = masked >> `SCS_L2_64K_BITS;
			l2_index_o = index_i[9:0];
			addr_o = base + {29'h0, l1_idx, 3'h0};
		end else begin
			align_mask = ~({32'h0, scs_low_bits(20'hF_FFFF, count_log2_i)} << `SCS_CD_SHIFT); // [R20]
			addr_o = (base & align_mask) + ({32'h0, lin_idx} << `SCS_CD_SHIFT); // [R22]
		end
	end
endmodule : scs_index_calc

// file: rtl/scs_context_select.sv
// Stream context select: sub-flow checks, default policy and descriptor address
`timescale 1ns/1ps
`include "scs_defines.svh"
// Summary of operation
// [R01] Stage one off: abort indexed traffic, flag
// [R02] Zero count or width: one descriptor only
// [R03] Two-level format needs two-level support
// [R04] Stage two on: pointers are intermediate addresses
// [R05] Pointer holds bits 51:6, rest zero
// [R06] Stage two translates pointer; software keeps range
// [R07] Stage one off: pointer ignored
// [R08] Count field is log2 of descriptors
// [R09] Zero id width: abort indexed traffic
// [R10] Zero count: one descriptor, abort indexed
// [R11] Index beyond span aborts, flag event
// [R12] Count must not exceed id width
// [R13] Policy governs unindexed traffic when enabled
// [R14] Terminate policy: abort, stream disabled fault
// [R15] Bypass policy: skip stage one, size check
// [R16] Bypass fetches no descriptor, no fetch faults
// [R17] Sub-flow zero policy: use descriptor zero
// [R18] Sub-flow zero policy: index zero aborts
// [R19] Reserved policy acts as terminate
// [R20] Linear table indexed by low index bits
// [R21] Two-level: high bits first, low second
// [R22] Fetch address is base plus index times 64
module scs_context_select (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic txn_valid_i,
	input wire scs_pkg::scs_txn_t txn_i,
	output logic ans_valid_o,
	output scs_pkg::scs_ans_t ans_o,
	output logic invalid_substream_event_o,
	output logic stream_disabled_fault_o
);
	import scs_pkg::*;

	// Software visible state
	logic [2:0] stream_config;
	logic [45:0] context_table_pointer;
	logic [1:0] context_table_format;
	logic [4:0] context_count_log2;
	logic [1:0] default_substream_policy;
	logic [4:0] substream_id_width;
	logic two_level_context_supported;
	logic [5:0] input_address_size;
	logic [15:0] bad_sub_count;
	logic [15:0] disabled_count;
	logic [2:0] next_stream_config;
	logic [45:0] next_context_table_pointer;
	logic [1:0] next_context_table_format;
	logic [4:0] next_context_count_log2;
	logic [1:0] next_default_substream_policy;
	logic [4:0] next_substream_id_width;
	logic next_two_level_context_supported;
	logic [5:0] next_input_address_size;
	logic [15:0] next_bad_sub_count;
	logic [15:0] next_disabled_count;
	logic [31:0] next_reg_rdata;

	// Answer path state
	logic next_ans_valid;
	scs_ans_t next_ans;
	logic next_bad_event;
	logic next_dis_event;

	logic s1_en;
	logic s2_en;
	logic subs_on;
	logic [1:0] eff_fmt;
	logic [1:0] eff_policy;
	logic [51:0] calc_addr;
	logic calc_two_level;
	logic [9:0] calc_l2;
	logic [19:0] use_index;
	logic in_span;
	logic addr_too_big;
	logic illegal_cfg;

	// Stream configuration bits: bit 0 enables stage one, bit 1 stage two
	assign s1_en = stream_config[0];
	assign s2_en = stream_config[1];
	// Sub-flows live only with stage one, a non-zero count and support for ids
	assign subs_on = s1_en && (context_count_log2 != 5'h00) && (substream_id_width != 5'h00);
	// Format ignored unless sub-flows are live; reserved format behaves as linear once two-level support is set
	assign eff_fmt = (subs_on && context_table_format != 2'h3) ?
		context_table_format : `SCS_FMT_LINEAR; // [R02]
	// Reserved policy folds onto terminate
	assign eff_policy = (default_substream_policy == 2'h3) ?
		`SCS_DSS_TERM : default_substream_policy; // [R19]
	assign use_index = (txn_i.has_index && subs_on) ? txn_i.sub_flow_index : 20'h0_0000;
	// Span is 2 to the count; indices at or above it are out of range
	assign in_span = ({12'h000, txn_i.sub_flow_index} >> context_count_log2) == 32'h0; // [R08] [R11]
	// Stage one address size: any bit at or above the input size is out of range
	assign addr_too_big = (txn_i.input_addr >> input_address_size) != 52'h0; // [R15]
	// Bad programming is reported as a bad sub-flow on indexed traffic and in the status register
	assign illegal_cfg = (subs_on && !two_level_context_supported &&
		context_table_format != `SCS_FMT_LINEAR) || // [R03]
		(s1_en && context_count_log2 > substream_id_width && substream_id_width != 5'h00); // [R12]

	// Address former; the count is forced to zero when sub-flows are off so
	// that a stale count cannot skew the single descriptor address
	scs_index_calc u_calc (
		.ctx_ptr_i(context_table_pointer),
		.fmt_i(eff_fmt),
		.count_log2_i(subs_on ? context_count_log2 : 5'h00),
		.index_i(use_index),
		.addr_o(calc_addr),
		.two_level_o(calc_two_level),
		.l2_index_o(calc_l2)
	);

	// Decide how the incoming transaction is handled
	always_comb begin
		next_ans_valid = txn_valid_i;
		next_ans = '0;
		next_ans.result = SCS_RES_NONE;
		next_bad_event = 1'b0;
		next_dis_event = 1'b0;
		next_ans.addr_is_ipa = s2_en; // [R04] [R06]
		next_ans.s2_after = s2_en;
		// Refusals are tested first so a bad index never reaches a fetch
		if (txn_valid_i) begin
			if (!s1_en) begin
				// Pointer untouched here; only stage two may follow
				if (txn_i.has_index) begin
					next_ans.result = SCS_RES_BAD_SUBSTREAM; // [R01] [R07]
					next_bad_event = 1'b1;
				end else begin
					next_ans.result = SCS_RES_S1_BYPASS;
				end
			end else if (txn_i.has_index) begin
				if (substream_id_width == 5'h00 || context_count_log2 == 5'h00) begin
					next_ans.result = SCS_RES_BAD_SUBSTREAM; // [R09] [R10]
					next_bad_event = 1'b1;
				end else if (!in_span || illegal_cfg) begin
					next_ans.result = SCS_RES_BAD_SUBSTREAM; // [R11]
					next_bad_event = 1'b1;
				end else if (eff_policy == `SCS_DSS_SUB0 &&
					txn_i.sub_flow_index == 20'h0_0000) begin
					next_ans.result = SCS_RES_STREAM_DISABLED; // [R18]
					next_dis_event = 1'b1;
				end else begin
					next_ans.result = calc_two_level ? SCS_RES_FETCH_L1 : SCS_RES_FETCH_CD; // [R21]
					next_ans.fetch_addr = calc_addr; // [R22]
					next_ans.l2_index = calc_l2;
				end
			end else if (!subs_on) begin
				// One descriptor at the pointer itself
				next_ans.result = SCS_RES_FETCH_CD; // [R02] [R10]
				next_ans.fetch_addr = {context_table_pointer, 6'h00}; // [R05]
			end else begin
				unique case (eff_policy) // [R13]
					`SCS_DSS_BYPASS: begin
						// No fetch address leaves, so no fetch fault can follow
						if (addr_too_big) begin
							next_ans.result = SCS_RES_S1_ADDR_SIZE; // [R15]
							next_ans.s2_after = 1'b0;
						end else begin
							next_ans.result = SCS_RES_S1_BYPASS; // [R15] [R16]
						end
					end
					`SCS_DSS_SUB0: begin
						next_ans.result = calc_two_level ? SCS_RES_FETCH_L1 : SCS_RES_FETCH_CD; // [R17]
						next_ans.fetch_addr = calc_addr;
						next_ans.l2_index = calc_l2;
					end
					default: begin
						next_ans.result = SCS_RES_STREAM_DISABLED; // [R14]
						next_dis_event = 1'b1;
					end
				endcase
			end
		end
	end

	// Register the answer; a transaction is answered in the following cycle
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ans_valid_o <= 1'b0;
			ans_o <= '0;
			invalid_substream_event_o <= 1'b0;
			stream_disabled_fault_o <= 1'b0;
		end else begin
			ans_valid_o <= next_ans_valid;
			ans_o <= next_ans;
			invalid_substream_event_o <= next_bad_event;
			stream_disabled_fault_o <= next_dis_event;
		end
	end

	// Register writes, event counters and read mux
	always_comb begin
		next_stream_config = stream_config;
		next_context_table_pointer = context_table_pointer;
		next_context_table_format = context_table_format;
		next_context_count_log2 = context_count_log2;
		next_default_substream_policy = default_substream_policy;
		next_substream_id_width = substream_id_width;
		next_two_level_context_supported = two_level_context_supported;
		next_input_address_size = input_address_size;
		next_bad_sub_count = bad_sub_count;
		next_disabled_count = disabled_count;
		next_reg_rdata = 32'h0000_0000;
		// Counters saturate rather than wrap so a flood is still visible
		if (next_bad_event && bad_sub_count != 16'hFFFF) begin
			next_bad_sub_count = bad_sub_count + 16'h0001;
		end
		if (next_dis_event && disabled_count != 16'hFFFF) begin
			next_disabled_count = disabled_count + 16'h0001;
		end
		// Unmapped indices are ignored on write and read back as zero
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`SCS_REG_CTRL: next_stream_config = reg_wdata_i[2:0];
				`SCS_REG_PTR_LO: next_context_table_pointer[25:0] = reg_wdata_i[31:6];
				`SCS_REG_PTR_HI: next_context_table_pointer[45:26] = reg_wdata_i[19:0];
				`SCS_REG_FIELDS: begin
					next_context_table_format = reg_wdata_i[1:0];
					next_context_count_log2 = reg_wdata_i[12:8];
					next_default_substream_policy = reg_wdata_i[17:16];
				end
				`SCS_REG_CAPS: begin
					next_substream_id_width = reg_wdata_i[4:0];
					next_two_level_context_supported = reg_wdata_i[8];
					next_input_address_size = reg_wdata_i[21:16];
				end
				// Write to the event register clears both counters; a same-cycle event wins
				`SCS_REG_EVENTS: begin
					next_bad_sub_count = {15'h0000, next_bad_event};
					next_disabled_count = {15'h0000, next_dis_event};
				end
				default: begin
				end
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`SCS_REG_CTRL: next_reg_rdata = {29'h0000_0000, stream_config};
				`SCS_REG_PTR_LO: next_reg_rdata = {context_table_pointer[25:0], 6'h00};
				`SCS_REG_PTR_HI: next_reg_rdata = {12'h000, context_table_pointer[45:26]};
				`SCS_REG_FIELDS: next_reg_rdata = {14'h0000, default_substream_policy,
					3'h0, context_count_log2, 6'h00, context_table_format};
				`SCS_REG_CAPS: next_reg_rdata = {10'h000, input_address_size, 7'h00,
					two_level_context_supported, 3'h0, substream_id_width};
				`SCS_REG_EVENTS: next_reg_rdata = {disabled_count, bad_sub_count};
				`SCS_REG_COUNT: next_reg_rdata = {31'h0000_0000, illegal_cfg};
				default: next_reg_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Register state; read data holds only for the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stream_config <= `SCS_CTRL_RST;
			context_table_pointer <= '0;
			context_table_format <= 2'h0;
			context_count_log2 <= 5'h00;
			default_substream_policy <= 2'h0;
			substream_id_width <= 5'h00;
			two_level_context_supported <= 1'b0;
			// Input address size leaves reset at its default width
			input_address_size <= `SCS_IAS_RST;
			bad_sub_count <= 16'h0000;
			disabled_count <= 16'h0000;
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			stream_config <= next_stream_config;
			context_table_pointer <= next_context_table_pointer;
			context_table_format <= next_context_table_format;
			context_count_log2 <= next_context_count_log2;
			default_substream_policy <= next_default_substream_policy;
			substream_id_width <= next_substream_id_width;
			two_level_context_supported <= next_two_level_context_supported;
			input_address_size <= next_input_address_size;
			bad_sub_count <= next_bad_sub_count;
			disabled_count <= next_disabled_count;
			reg_rdata_o <= next_reg_rdata;
		end
	end
endmodule : scs_context_select

// file: sim/scs_context_select_sva.sv
// Port-level checks for the context select block
`timescale 1ns/1ps
module scs_context_select_sva (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic txn_valid_i,
	input wire scs_pkg::scs_txn_t txn_i,
	input wire logic ans_valid_o,
	input wire scs_pkg::scs_ans_t ans_o,
	input wire logic invalid_substream_event_o,
	input wire logic stream_disabled_fault_o
);
	import scs_pkg::*;
	logic [2:0] ctl;
	logic [17:0] fld;
	logic [8:0] cap;
	logic s2;
	logic on;
	logic ok;
	// Shadow of the configuration; writes land at the same edge as in the block
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl <= 3'h0;
			fld <= 18'h0_0000;
			cap <= 9'h000;
		end else if (reg_wr_i) begin
			if (reg_addr_i == 4'h0) ctl <= reg_wdata_i[2:0];
			if (reg_addr_i == 4'h3) fld <= reg_wdata_i[17:0];
			if (reg_addr_i == 4'h4) cap <= reg_wdata_i[8:0];
		end
	end
	// Sub-flows live only with stage one, a width and a count
	assign s2 = ctl[1];
	assign on = ctl[0] && cap[4:0] != 5'h00 && fld[12:8] != 5'h00;
	assign ok = fld[12:8] <= cap[4:0] && (fld[1:0] == 2'h0 || cap[8]);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence bad_s;
		invalid_substream_event_o && ans_o.result == SCS_RES_BAD_SUBSTREAM;
	endsequence
	sequence dis_s;
		stream_disabled_fault_o && ans_o.result == SCS_RES_STREAM_DISABLED;
	endsequence
	ans_next_a: assert property (txn_valid_i |=> ans_valid_o)
		else $error("answer missing after transaction");
	ans_quiet_a: assert property (!txn_valid_i |=> !ans_valid_o && !invalid_substream_event_o
		&& !stream_disabled_fault_o) else $error("answer without transaction");
	s1_off_idx_a: assert property (txn_valid_i && !ctl[0] && txn_i.has_index |=> bad_s)
		else $error("indexed traffic not aborted with stage one off");
	s1_off_pass_a: assert property (txn_valid_i && !ctl[0] && !txn_i.has_index |=>
		ans_o.result == SCS_RES_S1_BYPASS) else $error("pointer used with stage one off");
	sub_off_a: assert property (txn_valid_i && ctl[0] && txn_i.has_index &&
		(cap[4:0] == 5'h00 || fld[12:8] == 5'h00) |=> bad_s) else $error("index taken unused");
	span_a: assert property (txn_valid_i && on && txn_i.has_index &&
		(txn_i.sub_flow_index >> fld[12:8]) != 20'h0_0000 |=> bad_s) else $error("span check");
	term_a: assert property (txn_valid_i && on && !txn_i.has_index &&
		fld[17] == fld[16] |=> dis_s) else $error("terminate policy not applied");
	sub0_a: assert property (txn_valid_i && on && ok && txn_i.has_index &&
		txn_i.sub_flow_index == 20'h0_0000 && fld[17:16] == 2'h2 |=> dis_s)
		else $error("index zero not refused");
	bypass_a: assert property (txn_valid_i && on && !txn_i.has_index &&
		fld[17:16] == 2'h1 |=> ans_o.result inside {SCS_RES_S1_BYPASS, SCS_RES_S1_ADDR_SIZE})
		else $error("bypass policy fetched");
	ipa_a: assert property (txn_valid_i ##1 ans_o.result == SCS_RES_FETCH_CD |->
		ans_o.addr_is_ipa == $past(s2) && ans_o.fetch_addr[5:0] == 6'h00)
		else $error("fetch address space or alignment");
	rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
		else $error("read data outside its cycle");
endmodule : scs_context_select_sva

// file: sim/scs_master_model.sv
// Device master model that issues translation transactions
`timescale 1ns/1ps
module scs_master_model (
	input wire logic clk_i,
	output logic txn_valid_o,
	output scs_pkg::scs_txn_t txn_o
);
	import scs_pkg::*;
	// Quiet bus at time zero
	initial begin
		txn_valid_o = 1'b0;
		txn_o = '0;
	end
	// Called just after an edge; back to back calls give back to back transactions
	task automatic send(input scs_txn_t t);
		txn_valid_o <= 1'b1;
		txn_o <= t;
	endtask : send
	// Idle fields flip on each call so stale values can never pass for intent
	task automatic stop();
		txn_valid_o <= 1'b0;
		txn_o <= ~txn_o;
	endtask : stop
endmodule : scs_master_model

// file: sim/tb_substream_context_select.sv
// Self-checking bench for the context select block
`timescale 1ns/1ps
module tb_substream_context_select;
	import scs_pkg::*;
	typedef struct packed {
		scs_result_t res;
		logic [51:0] fa;
		logic [9:0] l2;
		logic intermediate_physical_address;
		logic cf;
	} scs_exp_t;
	localparam scs_result_t r_bad = SCS_RES_BAD_SUBSTREAM;
	localparam scs_result_t r_dis = SCS_RES_STREAM_DISABLED;
	localparam scs_result_t r_cd = SCS_RES_FETCH_CD;
	logic clk_i;
	logic rst_b_i;
	logic [3:0] reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic reg_wr_i;
	logic reg_rd_i;
	logic [31:0] reg_rdata_o;
	logic txn_valid_i;
	scs_txn_t txn_i;
	logic ans_valid_o;
	scs_ans_t ans_o;
	logic invalid_substream_event_o;
	logic stream_disabled_fault_o;
	scs_exp_t eq[$];
	logic [31:0] rq[$];
	scs_exp_t e;
	logic rd_p = 1'b0;
	logic s2 = 1'b0;
	logic [51:0] base;
	logic [19:0] idx;
	int n_errors = 0;
	int checks_done = 0;
	int i;
	scs_context_select dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .txn_valid_i(txn_valid_i), .txn_i(txn_i),
		.ans_valid_o(ans_valid_o), .ans_o(ans_o),
		.invalid_substream_event_o(invalid_substream_event_o),
		.stream_disabled_fault_o(stream_disabled_fault_o));
	scs_master_model mdl (.clk_i(clk_i), .txn_valid_o(txn_valid_i), .txn_o(txn_i));
	// Clock at 40 MHz
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	// One register cycle; for a read the data argument is the expected value
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= w;
		reg_rd_i <= !w;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		mdl.stop();
		if (!w) rq.push_back(d);
	endtask : bus
	// One transaction plus its expected answer
	task automatic tx(input logic h, input logic [19:0] x, input scs_result_t r,
			input logic [51:0] f = '0, input logic [9:0] l = '0, input logic [51:0] a = '0);
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		mdl.send(scs_txn_t'{x, h, a});
		eq.push_back(scs_exp_t'{r, f, l, s2, r inside {r_cd, SCS_RES_FETCH_L1}});
	endtask : tx
	// Results are matched in order against the notes left by the drivers
	always @(posedge clk_i) begin
		if (rd_p) chk(reg_rdata_o, rq.pop_front());
		rd_p = reg_rd_i;
		if (ans_valid_o === 1'b1) begin
			chk(eq.size() != 0, 1'b1);
			e = eq.pop_front();
			chk(ans_o.result, e.res);
			chk(invalid_substream_event_o, e.res == r_bad);
			chk(stream_disabled_fault_o, e.res == r_dis);
			if (e.cf) chk({ans_o.fetch_addr, ans_o.addr_is_ipa}, {e.fa, e.intermediate_physical_address});
			else chk(ans_o.fetch_addr, 52'h0);
			// Stage-two flags follow the config; s2_after is cleared only by an address size fault
			chk({ans_o.addr_is_ipa, ans_o.s2_after},
				{e.intermediate_physical_address, e.intermediate_physical_address && e.res != SCS_RES_S1_ADDR_SIZE});
			if (e.res == SCS_RES_FETCH_L1) chk(ans_o.l2_index, e.l2);
		end
	end
	// Hang guard at 3000 cycles, far beyond the fifty or so cycles the run needs
	initial begin
		#(25 * 3000);
		n_errors++;
		close_out();
	end
	initial begin
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h0000_0000;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		rst_b_i = 1'b0;
		void'($urandom(32'he05b));
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		bus(0, 4'h0, 32'h0000_0000);
		bus(0, 4'h4, 32'h0030_0000);
		bus(0, 4'hf, 32'h0000_0000);
		tx(1, 20'h0_0003, r_bad);
		tx(0, 20'h0_0000, SCS_RES_S1_BYPASS);
		// Pointer kept inside the address range; low bits written must be dropped
		base = {4'h0, 32'($urandom), 16'h0000};
		bus(1, 4'h1, base[31:0] | 32'h0000_003f);
		bus(1, 4'h2, {12'h000, base[51:32]});
		bus(1, 4'h0, 32'h0000_0001);
		bus(0, 4'h1, base[31:0]);
		tx(1, 20'h0_0001, r_bad);
		tx(0, 20'h0_0000, r_cd, base);
		bus(1, 4'h4, 32'h0030_0014);
		tx(1, 20'h0_0001, r_bad);
		tx(0, 20'h0_0000, r_cd, base);
		bus(1, 4'h3, 32'h0000_0400);
		idx = 20'($urandom) & 20'h0_000f;
		tx(1, idx, r_cd, base + {idx, 6'h00});
		tx(1, 20'h0_000f, r_cd, base + 52'h3c0);
		tx(1, 20'h0_0010, r_bad);
		// Every default policy, without an index and with index zero
		for (i = 0; i < 4; i++) begin
			bus(1, 4'h3, {14'h0000, 2'(i), 16'h0400});
			tx(0, 20'h0_0000, i == 1 ? SCS_RES_S1_BYPASS : i == 2 ? r_cd : r_dis,
				base);
			tx(1, 20'h0_0000, i == 2 ? r_dis : r_cd, base);
		end
		bus(1, 4'h3, 32'h0001_0400);
		tx(0, 20'h0_0000, SCS_RES_S1_ADDR_SIZE, '0, '0, 52'h4_0000_0000_0000);
		bus(1, 4'h0, 32'h0000_0003);
		s2 = 1'b1;
		tx(1, idx, r_cd, base + {idx, 6'h00});
		// Two-level format, first refused for lack of support, then fetched; last a linear table with a count too large
		bus(1, 4'h3, 32'h0000_0a01);
		idx = 20'($urandom) & 20'h0_03ff;
		tx(1, idx, r_bad);
		bus(1, 4'h4, 32'h0030_0114);
		tx(1, idx, SCS_RES_FETCH_L1, base + {idx[9:6], 3'h0}, {4'h0, idx[5:0]});
		bus(1, 4'h3, 32'h0000_1500);
		tx(1, 20'h0_0001, r_bad);
		// Status flags the bad count; six refused indices and three disabled streams
		bus(0, 4'h6, 32'h0000_0001);
		bus(0, 4'h5, 32'h0003_0006);
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		mdl.stop();
		repeat (4) @(posedge clk_i);
		chk(eq.size() + rq.size(), 0);
		close_out();
	end
endmodule : tb_substream_context_select
bind scs_context_select scs_context_select_sva chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .txn_valid_i(txn_valid_i),
	.txn_i(txn_i), .ans_valid_o(ans_valid_o), .ans_o(ans_o),
	.invalid_substream_event_o(invalid_substream_event_o),
	.stream_disabled_fault_o(stream_disabled_fault_o));
